// *** src/bss_pkg.sv ***
// Package: constants and types for the bit-set and sleep execution block
package bss_pkg;

    // ****************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_INSTR = 12'h004;
    localparam logic [11:0] OFF_BANK = 12'h008;
    localparam logic [11:0] OFF_INDEX = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_WDOG = 12'h014;
    localparam logic [11:0] OFF_DPTR = 12'h018;
    localparam logic [11:0] OFF_DDATA = 12'h01C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_EXT_EN = 0;
    localparam int CTRL_WDOG_EN = 1;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_POWERDOWN = 1;
    localparam int ST_ASLEEP = 2;
    localparam int ST_WDOG_WAKE = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic TIMEOUT_RST = 1'b1;
    localparam logic POWERDOWN_RST = 1'b1;

    // ****************************************************************
    // Instruction encodings
    // ****************************************************************
    localparam logic [3:0] OPC_BIT_SET = 4'h8;
    localparam logic [15:0] OPC_SLEEP = 16'h0003;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 250;
    localparam int WDOG_PERIOD_MS = 16;
    localparam int WDOG_POST_DEF = 512;
    localparam longint WDOG_CYCLES = longint'(WDOG_PERIOD_MS) * 1000 * CLK_MHZ;
    localparam int WDOG_TICKS_DEF = int'(WDOG_CYCLES / WDOG_POST_DEF);

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [3:0] opcode;
        logic [2:0] bit_pos;
        logic bank_mode;
        logic [7:0] file_addr;
    } bss_bit_set_t;

    typedef struct packed {
        logic wdog_wake;
        logic asleep;
        logic powerdown_status_flag;
        logic timeout_status_flag;
    } bss_status_t;

endpackage

// *** src/bss_core.sv ***
// Module: bit-set and sleep instruction execution with APB register access
module bss_core #(
    parameter int DATA_AW = 12,
    parameter int WDOG_POST = bss_pkg::WDOG_POST_DEF,
    parameter int WDOG_TICKS = bss_pkg::WDOG_TICKS_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_req,
    output logic osc_stopped
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Refused at elaboration, before any clock runs
    if (DATA_AW != 12) begin
        $error("DATA_AW must be 12: bank and access bank need 12 bits");
    end
    if (WDOG_POST < 1 || WDOG_TICKS < 1) begin
        $error("Watchdog counts must be at least one");
    end

    localparam int DEPTH = 1 << DATA_AW;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] data_mem [DEPTH];
    logic [1:0] ctrl_reg;
    logic [3:0] bank_select_register;
    logic [DATA_AW-1:0] index_reg;
    logic [DATA_AW-1:0] dptr_reg;
    bss_pkg::bss_status_t status_reg;
    logic [31:0] post_reg;
    logic [31:0] watchdog_counter;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [15:0] last_instr_reg;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Answer one cycle into the access phase so every output is a flop
    wire access_wait = psel && penable && !pready_reg;
    wire access_done = psel && penable && pready_reg;
    wire wr_done = access_done && pwrite;
    wire hit_ctrl = paddr == bss_pkg::OFF_CTRL;
    wire hit_instr = paddr == bss_pkg::OFF_INSTR;
    wire hit_bank = paddr == bss_pkg::OFF_BANK;
    wire hit_index = paddr == bss_pkg::OFF_INDEX;
    wire hit_status = paddr == bss_pkg::OFF_STATUS;
    wire hit_wdog = paddr == bss_pkg::OFF_WDOG;
    wire hit_dptr = paddr == bss_pkg::OFF_DPTR;
    wire hit_ddata = paddr == bss_pkg::OFF_DDATA;
    wire mapped = hit_ctrl || hit_instr || hit_bank || hit_index || hit_status
        || hit_wdog || hit_dptr || hit_ddata;
    // Low lanes only carry data; narrow registers need lane 0 or lanes 0-1
    wire lane0 = pstrb[0];
    wire lane01 = pstrb[0] && pstrb[1];

    // ****************************************************************
    // Instruction decode and address formation
    // ****************************************************************
    function automatic logic [11:0] bss_data_addr(
        input bss_pkg::bss_bit_set_t ins,
        input logic ext_en,
        input logic [3:0] bank,
        input logic [11:0] index
    );
        logic low;
        low = ins.file_addr <= bss_pkg::INDEXED_LIMIT;
        if (ins.bank_mode) begin
            bss_data_addr = {bank, ins.file_addr};
        end else if (ext_en && low) begin
            bss_data_addr = index + {4'h0, ins.file_addr};
        end else if (low) begin
            bss_data_addr = {4'h0, ins.file_addr};
        end else begin
            bss_data_addr = {bss_pkg::ACCESS_HIGH_BANK, ins.file_addr};
        end
    endfunction

    wire bss_pkg::bss_bit_set_t ins = bss_pkg::bss_bit_set_t'(pwdata[15:0]);
    // A stopped core fetches nothing, so instruction writes while asleep are dropped
    wire exec_ok = wr_done && hit_instr && lane01 && !status_reg.asleep;
    wire do_bit_set = exec_ok && ins.opcode == bss_pkg::OPC_BIT_SET;
    wire do_sleep = exec_ok && pwdata[15:0] == bss_pkg::OPC_SLEEP;
    wire [11:0] bs_addr = bss_data_addr(ins, ctrl_reg[bss_pkg::CTRL_EXT_EN],
        bank_select_register, index_reg);
    wire [7:0] bs_mask = 8'h01 << ins.bit_pos;
    wire [7:0] bs_value = data_mem[bs_addr] | bs_mask;
    wire ddata_wr = wr_done && hit_ddata && lane0;

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    wire wdog_run = ctrl_reg[bss_pkg::CTRL_WDOG_EN];
    wire post_tick = post_reg == 32'(WDOG_POST - 1);
    wire wdog_expire = wdog_run && post_tick
        && watchdog_counter == 32'(WDOG_TICKS - 1);
    wire wdog_wake = wdog_expire && status_reg.asleep;
    wire other_wake = wake_req && status_reg.asleep;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [31:0] rd_value =
        hit_ctrl ? {30'h0000_0000, ctrl_reg} :
        hit_instr ? {16'h0000, last_instr_reg} :
        hit_bank ? {28'h000_0000, bank_select_register} :
        hit_index ? {20'h0_0000, index_reg} :
        hit_status ? {28'h000_0000, status_reg} :
        hit_wdog ? watchdog_counter :
        hit_dptr ? {20'h0_0000, dptr_reg} :
        hit_ddata ? {24'h00_0000, data_mem[dptr_reg]} : 32'h0000_0000;

    // ****************************************************************
    // APB response
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access_wait;
            pslverr_reg <= access_wait && !mapped;
            if (access_wait && !pwrite) begin
                prdata_reg <= rd_value;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= bss_pkg::CTRL_RST;
            bank_select_register <= 4'h0;
            index_reg <= '0;
            dptr_reg <= '0;
            last_instr_reg <= 16'h0000;
        end else begin
            if (wr_done && hit_ctrl && lane0) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (wr_done && hit_bank && lane0) begin
                bank_select_register <= pwdata[3:0];
            end
            if (wr_done && hit_index && lane01) begin
                index_reg <= pwdata[DATA_AW-1:0];
            end
            if (wr_done && hit_dptr && lane01) begin
                dptr_reg <= pwdata[DATA_AW-1:0];
            end
            if (exec_ok) begin
                last_instr_reg <= pwdata[15:0];
            end
        end
    end

    // ****************************************************************
    // Data memory
    // ****************************************************************
    // No reset on the array; contents are undefined until written
    always_ff @(posedge pclk) begin
        if (do_bit_set) begin
            data_mem[bs_addr] <= bs_value;
        end else if (ddata_wr) begin
            data_mem[dptr_reg] <= pwdata[7:0];
        end
    end

    // ****************************************************************
    // Watchdog counter and postscaler
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_reg <= 32'h0000_0000;
            watchdog_counter <= 32'h0000_0000;
        end else if (do_sleep || !wdog_run) begin
            post_reg <= 32'h0000_0000;
            watchdog_counter <= 32'h0000_0000;
        end else if (post_tick) begin
            post_reg <= 32'h0000_0000;
            watchdog_counter <= wdog_expire ? 32'h0000_0000 : watchdog_counter + 32'h0000_0001;
        end else begin
            post_reg <= post_reg + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // Sleep and status flags
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg.timeout_status_flag <= bss_pkg::TIMEOUT_RST;
            status_reg.powerdown_status_flag <= bss_pkg::POWERDOWN_RST;
            status_reg.asleep <= 1'b0;
            status_reg.wdog_wake <= 1'b0;
        end else if (do_sleep) begin
            status_reg.timeout_status_flag <= 1'b1;
            status_reg.powerdown_status_flag <= 1'b0;
            status_reg.asleep <= 1'b1;
            status_reg.wdog_wake <= 1'b0;
        end else if (wdog_wake) begin
            // Watchdog wins over a simultaneous external wake
            status_reg.timeout_status_flag <= 1'b0;
            status_reg.asleep <= 1'b0;
            status_reg.wdog_wake <= 1'b1;
        end else if (other_wake) begin
            status_reg.asleep <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign osc_stopped = status_reg.asleep;

endmodule

// *** tb/bss_core_asserts.sv ***
// Checker: port-level properties of the bit-set and sleep core
module bss_core_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_req,
    input wire logic osc_stopped
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire sleep_wr = acc && pready && pwrite && paddr == bss_pkg::OFF_INSTR
        && pstrb[1:0] == 2'b11 && pwdata[15:0] == bss_pkg::OPC_SLEEP;
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_wait_a: assert property (acc && !pready |=> pready) else $error("pready late");
    ready_cause_a: assert property (pready |-> acc && $past(acc)) else $error("stray pready");
    err_pulse_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    err_unmapped_a: assert property (acc && pready && paddr > bss_pkg::OFF_DDATA |-> pslverr)
        else $error("unmapped access not refused");
    sleep_enter_a: assert property (!osc_stopped && sleep_wr |=> osc_stopped)
        else $error("sleep not entered");
    sleep_cause_a: assert property ($rose(osc_stopped) |-> $past(sleep_wr))
        else $error("sleep without command");
    wake_exit_a: assert property (osc_stopped && wake_req |=> !osc_stopped)
        else $error("wake request ignored");
endmodule
bind bss_core bss_core_asserts bss_core_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_req(wake_req), .osc_stopped(osc_stopped)
);

// *** tb/bss_core_tb_top.sv ***
// Testbench: model-checked bit-set and sleep scenarios over APB
module bss_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake_req = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, osc_stopped, er;
    int n_fail = 0, n_tests = 0;
    int bank, idx, ext, f, b, a, v, ad, c;
    int exp_q[$];
    always #2 pclk = ~pclk;
    bss_core #(.WDOG_POST(4), .WDOG_TICKS(3)) bss_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_req(wake_req), .osc_stopped(osc_stopped)
    );
    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic apb(input logic w, input logic [11:0] ad_i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad_i;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No fixed wait; a hang is left to the watchdog process
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next setup never collides with this release
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #50000;
        n_fail++;
        finish_test();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(81854));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, bss_pkg::OFF_CTRL, 0);
        chk(rd, 32'h0000_0002);
        apb(0, bss_pkg::OFF_STATUS, 0);
        chk(rd, 32'h0000_0003);
        apb(0, 12'h020, 0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        $display("reset and map test done");
        for (int i = 0; i < 40; i++) begin
            bank = $urandom % 16;
            idx = $urandom % 4096;
            ext = (i < 4) ? (i < 2) : $urandom % 2;
            f = (i < 4) ? 'h5F + i % 2 : $urandom % 256;
            a = (i < 4) ? 0 : $urandom % 2;
            b = $urandom % 8;
            v = ($urandom % 256) & ~(1 << b);
            if (a) ad = bank * 256 + f;
            else if (ext && f <= 'h5F) ad = (idx + f) % 4096;
            else ad = (f <= 'h5F) ? f : 'hF00 + f;
            apb(1, bss_pkg::OFF_CTRL, 2 + ext);
            apb(1, bss_pkg::OFF_BANK, bank);
            apb(1, bss_pkg::OFF_INDEX, idx);
            apb(1, bss_pkg::OFF_DPTR, ad);
            apb(1, bss_pkg::OFF_DDATA, v);
            apb(1, bss_pkg::OFF_INSTR, 'h8000 + b * 512 + a * 256 + f);
            exp_q.push_back(v | (1 << b));
            apb(0, bss_pkg::OFF_DDATA, 0);
            chk(rd, exp_q.pop_front());
        end
        pstrb <= 4'h0;
        apb(1, bss_pkg::OFF_BANK, bank ^ 1);
        pstrb <= 4'hF;
        apb(0, bss_pkg::OFF_BANK, 0);
        chk(rd, bank);
        $display("bit set test done");
        apb(1, bss_pkg::OFF_CTRL, 0);
        apb(1, bss_pkg::OFF_INSTR, 3);
        chk({31'h0, osc_stopped}, 1);
        apb(0, bss_pkg::OFF_STATUS, 0);
        chk(rd, 32'h0000_0005);
        // Instruction writes are dropped while asleep: a bit set now must not execute
        apb(1, bss_pkg::OFF_INSTR, 'h8F00);
        apb(0, bss_pkg::OFF_INSTR, 0);
        chk(rd, 32'h0000_0003);
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        @(posedge pclk);
        chk({31'h0, osc_stopped}, 0);
        apb(0, bss_pkg::OFF_STATUS, 0);
        chk(rd, 32'h0000_0001);
        // Watchdog runs 4 x 3 cycles after the sleep clears it
        apb(1, bss_pkg::OFF_CTRL, 2);
        apb(1, bss_pkg::OFF_INSTR, 3);
        c = 0;
        while (osc_stopped === 1'b1 && c < 100) begin
            @(posedge pclk);
            c++;
        end
        chk(c >= 8 && c <= 14, 1);
        apb(0, bss_pkg::OFF_STATUS, 0);
        chk(rd, 32'h0000_0008);
        $display("sleep test done");
        finish_test();
    end
endmodule
